// ===== rtl/power_mgmt_serial_slave.sv
// Purpose: Two-wire power-management serial slave port with timeout, packet check and stream.
// Assumes: Bus pins are open drain; the user side feeds read bytes and drains written ones.
// Notes:   Written bytes leave as a stream closed by an end word carrying the packet verdict.
`timescale 1ns/1ps
module power_mgmt_serial_slave #(
  parameter int TOUT_BASE_CYC = pm_serial_pkg::TOUT_BASE_CYC,
  parameter int TOUT_LONG_CYC = pm_serial_pkg::TOUT_LONG_CYC,
  parameter int BLK_BYTE_CYC  = pm_serial_pkg::BLK_BYTE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic [6:0]  addrStrap,
  input  wire logic        alertPending,
  output logic             rxValid,
  output logic [7:0]       rxData,
  output logic             rxFirst,
  output logic             rxEnd,
  output logic             rxGood,
  output logic             rxPecOk,
  input  wire logic        rxReady,
  input  wire logic        txValid,
  input  wire logic [7:0]  txData,
  output logic             txReady,
  output logic [7:0]       pecByte,
  output logic [7:0]       cfgByte,
  output logic [7:0]       devAddress,
  output logic [15:0]      wordMant,
  output logic [4:0]       wordExp,
  output logic             wordValid
);
  localparam int TW = pm_serial_pkg::TMR_W;

  pm_serial_pkg::link_state_e state_q;
  logic [1:0]  sclSync_q, sdaSync_q, strapCnt_q;
  logic [6:0]  strapA_q, strapB_q;
  logic        sclPrev_q, sdaPrev_q;
  logic        scl, sda, sclRise, sclFall, startDet, stopDet;
  logic [2:0]  bitCnt_q, byteCnt_q;
  logic [7:0]  shift_q, crc_q, cmd_q, d0_q, d1_q, loadByte;
  logic        byteFull_q, isRead_q, txWait_q, firstTx_q, holdAck_q;
  logic        pktOpen_q, endPend_q, endGood_q, missPulse_q;
  logic        pushValid_q, bufInReady, canPush, addrHit, stretchEn, abort;
  logic [pm_serial_pkg::RX_W-1:0] pushData_q, bufOut;
  logic [TW-1:0] tmr_q, extra_q, limit;
  logic        tmrRun_q, cmdOk;
  logic [15:0] word;

  // A 125 MHz sampler resolves every bus rate up to 400 kHz.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
    end
  end

  assign scl      = sclSync_q[1];
  assign sda      = sdaSync_q[1];
  assign sclRise  = scl & ~sclPrev_q;
  assign sclFall  = ~scl & sclPrev_q;
  assign startDet = scl & sclPrev_q & ~sda & sdaPrev_q;
  assign stopDet  = scl & sclPrev_q & sda & ~sdaPrev_q;

  assign stretchEn = cfgByte[pm_serial_pkg::CFG_STRETCH];
  assign canPush   = bufInReady & ~pushValid_q & ~endPend_q;
  assign pecByte   = crc_q;
  assign sclOut    = 1'b0;
  assign sdaOut    = 1'b0;

  // Global address answers always, alongside device and alert query.
  // The device address answers only while not disabled.
  assign addrHit = (shift_q[7:1] == pm_serial_pkg::GLOBAL_ADDR)
                 || (devAddress != pm_serial_pkg::ADDR_DISABLE
                     && shift_q[7:1] == devAddress[6:0])
                 || (shift_q[7:1] == pm_serial_pkg::ARA_ADDR && shift_q[0] && alertPending);

  // Config bit 3 selects the long packet timeout.
  assign limit = (cfgByte[pm_serial_pkg::CFG_LONG_TOUT] ? TW'(TOUT_LONG_CYC)
                                                        : TW'(TOUT_BASE_CYC)) + extra_q;
  // Running past the limit aborts the packet.
  assign abort = tmrRun_q & (tmr_q >= limit);

  // Timer starts at a first START only.
  // A repeated START keeps the same timer running.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tmr_q    <= '0;
      tmrRun_q <= 1'b0;
    end else if (abort || stopDet || missPulse_q) begin
      tmrRun_q <= 1'b0;
    end else if (startDet && !tmrRun_q) begin
      tmrRun_q <= 1'b1;
      tmr_q    <= '0;
    end else if (tmrRun_q) begin
      tmr_q <= tmr_q + TW'(1);
    end
  end

  assign loadByte = txValid ? txData : pm_serial_pkg::IDLE_BYTE;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q     <= pm_serial_pkg::ST_IDLE;
      bitCnt_q    <= 3'h0;
      byteCnt_q   <= 3'h0;
      shift_q     <= 8'h00;
      crc_q       <= 8'h00;
      cmd_q       <= 8'h00;
      d0_q        <= 8'h00;
      d1_q        <= 8'h00;
      byteFull_q  <= 1'b0;
      isRead_q    <= 1'b0;
      txWait_q    <= 1'b0;
      firstTx_q   <= 1'b0;
      holdAck_q   <= 1'b0;
      pktOpen_q   <= 1'b0;
      endPend_q   <= 1'b0;
      endGood_q   <= 1'b0;
      missPulse_q <= 1'b0;
      pushValid_q <= 1'b0;
      pushData_q  <= '0;
      extra_q     <= '0;
      sdaOe       <= 1'b0;
      sclOe       <= 1'b0;
      txReady     <= 1'b0;
    end else begin
      txReady     <= 1'b0;
      missPulse_q <= 1'b0;
      if (pushValid_q && bufInReady) begin
        pushValid_q <= 1'b0;
      end
      if (abort) begin
        // Release both drivers and discard the packet.
        state_q   <= pm_serial_pkg::ST_IDLE;
        sdaOe     <= 1'b0;
        sclOe     <= 1'b0;
        txWait_q  <= 1'b0;
        holdAck_q <= 1'b0;
        endPend_q <= pktOpen_q;
        endGood_q <= 1'b0;
        pktOpen_q <= 1'b0;
      end else if (startDet) begin
        state_q    <= pm_serial_pkg::ST_ADDR;
        bitCnt_q   <= 3'h0;
        byteFull_q <= 1'b0;
        sdaOe      <= 1'b0;
        sclOe      <= 1'b0;
        txWait_q   <= 1'b0;
        holdAck_q  <= 1'b0;
        if (!tmrRun_q) begin
          crc_q     <= 8'h00;
          byteCnt_q <= 3'h0;
          extra_q   <= '0;
        end
      end else if (stopDet) begin
        state_q   <= pm_serial_pkg::ST_IDLE;
        sdaOe     <= 1'b0;
        sclOe     <= 1'b0;
        txWait_q  <= 1'b0;
        holdAck_q <= 1'b0;
        endPend_q <= pktOpen_q;
        endGood_q <= 1'b1;
        pktOpen_q <= 1'b0;
      end else begin
        unique case (state_q)
          pm_serial_pkg::ST_IDLE, pm_serial_pkg::ST_WAIT: begin
          end
          pm_serial_pkg::ST_ADDR, pm_serial_pkg::ST_WDAT: begin
            if (sclRise) begin
              shift_q  <= {shift_q[6:0], sda};
              bitCnt_q <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'h7) begin
                byteFull_q <= 1'b1;
              end
            end else if ((sclFall && byteFull_q) || holdAck_q) begin
              if (state_q == pm_serial_pkg::ST_ADDR && !addrHit) begin
                state_q     <= pm_serial_pkg::ST_WAIT;
                missPulse_q <= 1'b1;
                byteFull_q  <= 1'b0;
              end else if (canPush) begin
                // Accept the byte by pulling the acknowledge bit low.
                // Every byte, check byte included, goes through the same path.
                sdaOe       <= 1'b1;
                sclOe       <= 1'b0;
                holdAck_q   <= 1'b0;
                byteFull_q  <= 1'b0;
                pushValid_q <= 1'b1;
                pushData_q  <= {3'b000, state_q == pm_serial_pkg::ST_ADDR, shift_q};
                // Check code runs over every byte, addresses included.
                crc_q       <= pm_serial_pkg::crc8(crc_q, shift_q);
                if (byteCnt_q != 3'h7) begin
                  byteCnt_q <= byteCnt_q + 3'h1;
                end
                // Second byte of a packet is the command code.
                // Following bytes are data, then the optional check byte.
                unique case (byteCnt_q)
                  3'h1:    cmd_q <= shift_q;
                  3'h2:    d0_q  <= shift_q;
                  3'h3:    d1_q  <= shift_q;
                  default: begin
                  end
                endcase
                if (state_q == pm_serial_pkg::ST_ADDR) begin
                  // Low address bit chooses read when set.
                  isRead_q  <= shift_q[0];
                  firstTx_q <= 1'b1;
                  pktOpen_q <= 1'b1;
                  state_q   <= pm_serial_pkg::ST_AACK;
                end else begin
                  state_q <= pm_serial_pkg::ST_WACK;
                end
              end else if (stretchEn) begin
                // Hold the clock only while stretching is enabled.
                holdAck_q <= 1'b1;
                sclOe     <= 1'b1;
              end else begin
                // Refuse by leaving the acknowledge bit high.
                state_q    <= pm_serial_pkg::ST_WAIT;
                byteFull_q <= 1'b0;
              end
            end
          end
          pm_serial_pkg::ST_AACK: begin
            if (sclFall) begin
              sdaOe    <= 1'b0;
              bitCnt_q <= 3'h0;
              // After the address acknowledge a read turns the slave into sender.
              if (isRead_q) begin
                state_q  <= pm_serial_pkg::ST_RDAT;
                txWait_q <= 1'b1;
              end else begin
                state_q <= pm_serial_pkg::ST_WDAT;
              end
            end
          end
          pm_serial_pkg::ST_WACK: begin
            if (sclFall) begin
              sdaOe   <= 1'b0;
              state_q <= pm_serial_pkg::ST_WDAT;
            end
          end
          pm_serial_pkg::ST_RDAT: begin
            if (txWait_q) begin
              if (txValid || !stretchEn) begin
                shift_q  <= loadByte;
                sdaOe    <= ~loadByte[7];
                crc_q    <= pm_serial_pkg::crc8(crc_q, loadByte);
                txReady  <= txValid;
                txWait_q <= 1'b0;
                sclOe    <= 1'b0;
                bitCnt_q <= 3'h0;
                // First byte sent gives the block length and its extra time.
                // Any length up to 255 bytes is covered.
                if (firstTx_q) begin
                  extra_q <= TW'(32'(loadByte) * BLK_BYTE_CYC);
                end
                firstTx_q <= 1'b0;
              end else begin
                // Stretch while waiting for a byte, only when enabled.
                sclOe <= 1'b1;
              end
            end else if (sclRise) begin
              bitCnt_q <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'h7) begin
                byteFull_q <= 1'b1;
              end
            end else if (sclFall) begin
              if (byteFull_q) begin
                sdaOe      <= 1'b0;
                byteFull_q <= 1'b0;
                state_q    <= pm_serial_pkg::ST_RACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sdaOe   <= ~shift_q[6];
              end
            end
          end
          pm_serial_pkg::ST_RACK: begin
            // Reads continue byte by byte until the master refuses one.
            if (sclRise && sda) begin
              state_q <= pm_serial_pkg::ST_WAIT;
            end else if (sclFall) begin
              state_q  <= pm_serial_pkg::ST_RDAT;
              txWait_q <= 1'b1;
            end
          end
        endcase
      end
      if (endPend_q && bufInReady && !pushValid_q) begin
        pushValid_q <= 1'b1;
        pushData_q  <= {1'b1, endGood_q, crc_q == 8'h00, 9'h000};
        endPend_q   <= 1'b0;
      end
    end
  end

  pair_buffer #(
    .WIDTH    (pm_serial_pkg::RX_W)
  ) u_rx_buf (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .inValid  (pushValid_q),
    .inData   (pushData_q),
    .inReady  (bufInReady),
    .outValid (rxValid),
    .outData  (bufOut),
    .outReady (rxReady)
  );

  assign rxData  = bufOut[7:0];
  assign rxFirst = bufOut[pm_serial_pkg::RX_FIRST];
  assign rxPecOk = bufOut[pm_serial_pkg::RX_PEC];
  assign rxGood  = bufOut[pm_serial_pkg::RX_GOOD];
  assign rxEnd   = bufOut[pm_serial_pkg::RX_END];

  // A packet with a check byte commits only when the code matches.
  assign cmdOk = stopDet && pktOpen_q && !isRead_q && !abort;
  assign word  = {d1_q, d0_q};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strapA_q   <= 7'h00;
      strapB_q   <= 7'h00;
      strapCnt_q <= 2'h0;
      cfgByte    <= pm_serial_pkg::CFG_RESET;
      devAddress <= 8'h00;
      wordMant   <= 16'h0000;
      wordExp    <= 5'h00;
      wordValid  <= 1'b0;
    end else begin
      strapA_q  <= addrStrap;
      strapB_q  <= strapA_q;
      wordValid <= 1'b0;
      if (strapCnt_q != 2'h3) begin
        strapCnt_q <= strapCnt_q + 2'h1;
      end
      if (strapCnt_q == 2'h2) begin
        devAddress <= {1'b0, strapB_q};
      end
      if (cmdOk && (byteCnt_q == 3'h3 || (byteCnt_q == 3'h4 && crc_q == 8'h00))) begin
        if (cmd_q == pm_serial_pkg::CMD_CONFIG_ALL) begin
          cfgByte <= d0_q;
        end
        // Storing the disable code silences the device address.
        if (cmd_q == pm_serial_pkg::CMD_ADDR_SET) begin
          devAddress <= d0_q;
        end
      end
      if (cmdOk && cmd_q != pm_serial_pkg::CMD_CONFIG_ALL && cmd_q != pm_serial_pkg::CMD_ADDR_SET
          && (byteCnt_q == 3'h4 || (byteCnt_q == 3'h5 && crc_q == 8'h00))) begin
        wordValid <= 1'b1;
        if (cmd_q >= pm_serial_pkg::CMD_VOUT_FIRST && cmd_q <= pm_serial_pkg::CMD_VOUT_LAST) begin
          // Voltage words are unsigned with the fixed exponent.
          wordMant <= word;
          wordExp  <= pm_serial_pkg::VOUT_EXP;
        end else begin
          // Signed 11-bit mantissa, signed 5-bit exponent above it.
          wordMant <= {{5{word[10]}}, word[10:0]};
          wordExp  <= word[15:11];
        end
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_timer_start;
    startDet && !tmrRun_q && !abort && !stopDet |=> tmrRun_q && tmr_q == '0;
  endproperty
  a_timer_start: assert property (p_timer_start) else $error("timer not started");
  property p_abort_release;
    abort |=> !sdaOe && !sclOe && state_q == pm_serial_pkg::ST_IDLE;
  endproperty
  a_abort_release: assert property (p_abort_release) else $error("bus kept on abort");
  property p_long_tout;
    tmrRun_q && cfgByte[pm_serial_pkg::CFG_LONG_TOUT] && tmr_q < TW'(TOUT_LONG_CYC) |-> !abort;
  endproperty
  a_long_tout: assert property (p_long_tout) else $error("early abort in long mode");
  property p_restart_keeps;
    startDet && tmrRun_q && !abort |=> tmrRun_q && tmr_q == $past(tmr_q) + TW'(1);
  endproperty
  a_restart_keeps: assert property (p_restart_keeps) else $error("timer reset");
  property p_blk_extra;
    state_q == pm_serial_pkg::ST_RDAT && txWait_q && firstTx_q && txValid
      && !abort && !startDet && !stopDet |=> extra_q == TW'(32'($past(txData)) * BLK_BYTE_CYC);
  endproperty
  a_blk_extra: assert property (p_blk_extra) else $error("block extra wrong");
  property p_stretch_gate;
    sclOe |-> stretchEn;
  endproperty
  a_stretch_gate: assert property (p_stretch_gate) else $error("stretch disabled");
  property p_dir_bit;
    state_q == pm_serial_pkg::ST_AACK |-> isRead_q == shift_q[0];
  endproperty
  a_dir_bit: assert property (p_dir_bit) else $error("direction mismatch");
  property p_ack_low;
    $changed(state_q) && (state_q == pm_serial_pkg::ST_AACK
      || state_q == pm_serial_pkg::ST_WACK) |-> sdaOe ##1 sdaOe || sclFall;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not driven");
  property p_global_hit;
    state_q == pm_serial_pkg::ST_ADDR && sclFall && byteFull_q && canPush
      && shift_q[7:1] == pm_serial_pkg::GLOBAL_ADDR && !startDet && !stopDet && !abort
      |=> state_q == pm_serial_pkg::ST_AACK;
  endproperty
  a_global_hit: assert property (p_global_hit) else $error("global not acked");
  property p_idle_hold;
    state_q == pm_serial_pkg::ST_IDLE && !startDet |=> state_q == pm_serial_pkg::ST_IDLE;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("left idle without start");

  c_read_ack: cover property (state_q == pm_serial_pkg::ST_RACK ##1 sclFall);
  c_abort: cover property (abort);
  c_end_word: cover property (rxValid && rxEnd && rxGood && rxPecOk);
  c_stretch: cover property (sclOe [*3]);
endmodule : power_mgmt_serial_slave

// ===== common/pm_serial_pkg.sv
// Purpose: Shared constants, states and helpers for the power-management serial slave.
// Assumes: 125 MHz system clock; two-wire bus sampled by that clock.
// Notes:   Long timing counts are also top-level parameters so a bench can shorten them.
package pm_serial_pkg;
  localparam int CLK_KHZ       = 125000;
  localparam int TOUT_BASE_MS  = 35;
  localparam int TOUT_LONG_MS  = 255;
  localparam int BLK_EXTRA_MS  = 32;
  localparam int MAX_BLOCK_LEN = 255;
  localparam int TOUT_BASE_CYC = TOUT_BASE_MS * CLK_KHZ;
  localparam int TOUT_LONG_CYC = TOUT_LONG_MS * CLK_KHZ;
  localparam int BLK_BYTE_CYC  = (BLK_EXTRA_MS * CLK_KHZ) / MAX_BLOCK_LEN;
  localparam int TMR_W         = 26;
  localparam int RX_W          = 12;

  localparam logic [6:0] GLOBAL_ADDR    = 7'h5a;
  localparam logic [6:0] ARA_ADDR       = 7'h0c;
  localparam logic [7:0] ADDR_DISABLE   = 8'h80;
  localparam logic [7:0] CMD_CONFIG_ALL = 8'hd1;
  localparam logic [7:0] CMD_ADDR_SET   = 8'hd2;
  localparam logic [7:0] CMD_VOUT_FIRST = 8'h21;
  localparam logic [7:0] CMD_VOUT_LAST  = 8'h26;
  localparam logic [4:0] VOUT_EXP       = 5'h14;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [7:0] CRC_POLY       = 8'h07;
  localparam logic [7:0] IDLE_BYTE      = 8'hff;
  localparam int         CFG_STRETCH    = 1;
  localparam int         CFG_LONG_TOUT  = 3;

  // Stream word fields.
  localparam int RX_END   = 11;
  localparam int RX_GOOD  = 10;
  localparam int RX_PEC   = 9;
  localparam int RX_FIRST = 8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h2,
    ST_WDAT = 3'h3,
    ST_WACK = 3'h4,
    ST_RDAT = 3'h5,
    ST_RACK = 3'h6,
    ST_WAIT = 3'h7
  } link_state_e;

  // Packet error code step, polynomial x^8+x^2+x+1, msb first.
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8
endpackage : pm_serial_pkg

// ===== rtl/pair_buffer.sv
// Purpose: Two-entry buffer with valid and ready on both sides, all outputs from flops.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   The spare entry catches the word that arrives while the head is stalled.
`timescale 1ns/1ps
module pair_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  logic [WIDTH-1:0] spare_q;
  logic             spareFull_q;

  assign inReady = ~spareFull_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      outValid    <= 1'b0;
      outData     <= '0;
      spare_q     <= '0;
      spareFull_q <= 1'b0;
    end else if (!outValid || outReady) begin
      if (spareFull_q) begin
        outValid    <= 1'b1;
        outData     <= spare_q;
        spareFull_q <= 1'b0;
      end else begin
        outValid <= inValid;
        outData  <= inData;
      end
    end else if (inValid && !spareFull_q) begin
      spare_q     <= inData;
      spareFull_q <= 1'b1;
    end
  end
endmodule : pair_buffer

// ===== dv/bus_host.sv
// Purpose: Bus master model pulling the two open-drain bus lines low.
// Assumes: Bit time of 20 sys_clk cycles (160 ns link clock); steps on falling edges.
// Notes:   Waits out clock stretching for at most 400 cycles.
`timescale 1ns/1ps
module bus_host (
  input  wire logic sys_clk,
  input  wire logic sclWire,
  input  wire logic sdaWire,
  output logic      sclLow,
  output logic      sdaLow
);
  int timeouts;
  initial begin
    sclLow   = 1'b0;
    sdaLow   = 1'b0;
    timeouts = 0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : hold
  task automatic start();
    sdaLow = 1'b0;
    hold(10);
    sclLow = 1'b0;
    hold(10);
    sdaLow = 1'b1;
    hold(10);
    sclLow = 1'b1;
  endtask : start
  task automatic stop();
    sdaLow = 1'b1;
    hold(10);
    sclLow = 1'b0;
    hold(10);
    sdaLow = 1'b0;
    hold(10);
  endtask : stop
  task automatic bitIo(input logic b, output logic r);
    sdaLow = !b;
    hold(10);
    sclLow = 1'b0;
    for (int k = 0; k < 400 && !sclWire; k++) hold(1);
    if (!sclWire) timeouts++;
    hold(10);
    r = sdaWire;
    sclLow = 1'b1;
  endtask : bitIo
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
    bitIo(a, k);
  endtask : xfer
endmodule : bus_host

// ===== dv/power_mgmt_serial_slave_bench.sv
// Purpose: Self-checking bench for the power-management serial slave.
// Assumes: Shortened timeouts; device strap address 0x40.
// Notes:   Stream words are logged as {end, good, first, data}.
`timescale 1ns/1ps
module power_mgmt_serial_slave_bench;
  logic        sys_clk, resetn, rxReady, sclLow, sdaLow, sclOe, sdaOe, stretched;
  logic        rxValid, rxFirst, rxEnd, rxGood;
  logic [7:0]  rxData, cfgByte, q;
  logic        a, alertPending, txValid, txReady, rxPecOk, wordValid, sclOut, sdaOut;
  logic        sawTx, sawWord, lastPecOk;
  logic [7:0]  txData, pecByte, devAddress;
  logic [15:0] wordMant;
  logic [4:0]  wordExp;
  logic [10:0] seen[$];
  int          failures, n_checks;
  wire         sclWire = !(sclLow || sclOe);
  wire         sdaWire = !(sdaLow || sdaOe);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = !sys_clk;
  end
  power_mgmt_serial_slave #(.TOUT_BASE_CYC(2000), .TOUT_LONG_CYC(6000), .BLK_BYTE_CYC(10))
    i_power_mgmt_serial_slave (.sys_clk, .resetn, .sclIn(sclWire), .sclOut, .sclOe,
    .sdaIn(sdaWire), .sdaOut, .sdaOe, .addrStrap(7'h40), .alertPending, .rxValid,
    .rxData, .rxFirst, .rxEnd, .rxGood, .rxPecOk, .rxReady, .txValid,
    .txData, .txReady, .pecByte, .cfgByte, .devAddress, .wordMant, .wordExp,
    .wordValid);
  bus_host i_bus_host (.sys_clk, .sclWire, .sdaWire, .sclLow, .sdaLow);
  always @(posedge sys_clk) begin
    if (rxValid && rxReady) seen.push_back({rxEnd, rxGood, rxFirst, rxData});
    if (sclOe) stretched <= 1'b1;
    if (txReady) sawTx <= 1'b1;
    if (wordValid) sawWord <= 1'b1;
    if (rxValid && rxReady && rxEnd) lastPecOk <= rxPecOk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic pkt(input logic [7:0] b[$]);
    logic [7:0] r;
    logic       k;
    i_bus_host.start();
    foreach (b[i]) begin
      i_bus_host.xfer(b[i], 1'b1, r, k);
      chk(16'(k), 16'h0);
    end
    i_bus_host.stop();
    i_bus_host.hold(30);
    foreach (b[i]) chk(16'(seen.pop_front()), {5'h0, i == 0, b[i]});
    chk(16'(seen.pop_front() >> 8), 16'h6);
    $display("packet done");
  endtask : pkt
  initial begin
    #700000;
    failures++;
    $display("mismatch at %0t: run hung", $time);
    final_report();
  end
  initial begin
    resetn = 1'b0;
    rxReady = 1'b1;
    stretched = 1'b0;
    sawTx = 1'b0;
    sawWord = 1'b0;
    alertPending = 1'b0;
    txValid = 1'b1;
    txData = 8'ha5;
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    i_bus_host.hold(10);
    chk(16'(devAddress), 16'h40);
    chk(16'(pecByte), 16'h0);
    chk(16'({sclOut, sdaOut}), 16'h0);
    pkt('{8'hb4, 8'hd1, 8'h0a});
    chk(16'(cfgByte), 16'h0a);
    chk(16'(stretched), 16'h0);
    i_bus_host.start();
    i_bus_host.xfer(8'h66, 1'b1, q, a);
    chk(16'(a), 16'h1);
    i_bus_host.stop();
    seen.delete();
    $display("address miss done");
    rxReady = 1'b0;
    fork
      pkt('{8'h80, 8'h21, 8'h00, 8'h10});
      begin
        i_bus_host.hold(600);
        rxReady = 1'b1;
      end
    join
    chk(wordMant, 16'h1000);
    chk(16'(wordExp), 16'h14);
    chk(16'(stretched), 16'h1);
    chk(16'(sawWord), 16'h1);
    i_bus_host.start();
    i_bus_host.xfer(8'h80, 1'b1, q, a);
    i_bus_host.xfer(8'h21, 1'b1, q, a);
    i_bus_host.start();
    i_bus_host.xfer(8'h81, 1'b1, q, a);
    chk(16'(a), 16'h0);
    i_bus_host.xfer(8'hff, 1'b1, q, a);
    chk(16'(q), 16'ha5);
    i_bus_host.stop();
    chk(16'(sawTx), 16'h1);
    seen.delete();
    $display("read done");
    alertPending = 1'b1;
    i_bus_host.start();
    i_bus_host.xfer(8'h19, 1'b1, q, a);
    chk(16'(a), 16'h0);
    i_bus_host.xfer(8'hff, 1'b1, q, a);
    chk(16'(q), 16'ha5);
    i_bus_host.stop();
    alertPending = 1'b0;
    i_bus_host.hold(30);
    seen.delete();
    $display("alert query done");
    i_bus_host.start();
    i_bus_host.xfer(8'h80, 1'b1, q, a);
    i_bus_host.hold(4000);
    chk(16'(seen.size()), 16'h1);
    i_bus_host.hold(3000);
    chk(16'(seen[$] >> 8), 16'h4);
    chk(16'(sdaOe || sclOe), 16'h0);
    seen.delete();
    $display("timeout done");
    // The last byte is the check code of 0x80 and 0x03, so the packet closes clean.
    pkt('{8'h80, 8'h03, 8'hbf});
    chk(16'(lastPecOk), 16'h1);
    chk(16'(pecByte), 16'h0);
    chk(16'(i_bus_host.timeouts), 16'h0);
    final_report();
  end
endmodule : power_mgmt_serial_slave_bench
